// ===== verilog/ult_map.svh
`ifndef ULT_MAP_SVH
`define ULT_MAP_SVH

// Fixed-point layout of currents and intermediate values
`define ULT_CUR_W 16
`define ULT_WIDE_W 18
`define ULT_SUM_W 20
`define ULT_MAG_W 40
`define ULT_THETA_W 56
`define ULT_K_SHIFT 15
`define ULT_THIRD_SHIFT 16
`define ULT_Q16_SHIFT 16

// sqrt(3)/2 in Q1.15 and 1/3 in Q0.16
`define ULT_SQRT3_HALF 17'sh6ED9
`define ULT_ONE_THIRD 17'sh5555

// Percent squared, and the cold-clear fraction divisor
`define ULT_PCT_SQ 14'h2710
`define ULT_COLD_DIV 7'h64

// Timing
`define ULT_CLK_PERIOD_NS 32'h0000_0005
`define ULT_TICK_PERIOD_NS 32'h000F_4240
`define ULT_NS_PER_S 32'h3B9A_CA00

`endif

// ===== verilog/ult_pkg.sv
`include "ult_map.svh"

package ult_pkg;

   typedef enum logic [1:0]
   {
      ULT_S_IDLE = 2'h0,
      ULT_S_ROTATE = 2'h1,
      ULT_S_SUM = 2'h3,
      ULT_S_SQUARE = 2'h2
   } ult_state_t;

   typedef enum logic {ULT_ROT_ABC, ULT_ROT_ACB} ult_rot_t;
   typedef enum logic {ULT_REF_DEVICE, ULT_REF_OBJECT} ult_ref_t;
   typedef enum logic {fixed_delay_curve, heat_based_curve} ult_curve_t;

   typedef struct packed
   {
      logic signed [`ULT_CUR_W-1:0] re;
      logic signed [`ULT_CUR_W-1:0] im;
   } ult_phasor_t;

   typedef struct packed
   {
      ult_phasor_t l1;
      ult_phasor_t l2;
      ult_phasor_t l3;
   } ult_phases_t;

   typedef struct packed
   {
      logic signed [`ULT_WIDE_W-1:0] re;
      logic signed [`ULT_WIDE_W-1:0] im;
   } ult_cplx_t;

   typedef struct packed
   {
      logic [`ULT_MAG_W-1:0] pos_mag2;
      logic [`ULT_MAG_W-1:0] neg_mag2;
   } ult_seq_t;

   typedef struct packed
   {
      logic enable;
      ult_ref_t threshold_reference_select;
      ult_curve_t curve;
      logic ratio_en;
      logic [7:0] sequence_ratio_pickup_percent;
      logic [15:0] device_rated_unbalance_threshold;
      logic [15:0] object_rated_unbalance_threshold;
      logic [15:0] object_scale;
      logic [15:0] delay_ticks;
      logic [15:0] k_sec;
      logic [4:0] cool_shift;
   } ult_stage_cfg_t;

endpackage

// ===== verilog/ult_stage.sv
`timescale 1ns/10ps
`include "ult_map.svh"

module ult_stage
#(
   parameter int unsigned TICKS_PER_S = 1000
)
(
   input wire logic i_sys_clk,
   input wire logic i_arst_n,
   input wire logic i_tick,
   input wire logic i_clear,
   input wire ult_pkg::ult_seq_t i_seq,
   input wire ult_pkg::ult_stage_cfg_t i_cfg,
   output logic o_pickup,
   output logic o_trip
);
   import ult_pkg::*;

   localparam int TW = `ULT_THETA_W;
   localparam int MW = `ULT_MAG_W;

   logic [TW-1:0] theta;
   logic [TW-1:0] next_theta;
   logic [15:0] timer;
   logic [15:0] next_timer;
   logic pickup;
   logic next_pickup;
   logic trip;
   logic next_trip;
   logic [15:0] thr;
   logic [31:0] thr2;
   logic [31:0] scale2;
   logic [MW+31:0] scaled;
   logic [MW-1:0] ref_mag2;
   logic [MW+13:0] neg_pct;
   logic [MW+15:0] pos_pct;
   logic [15:0] ratio2;
   logic [TW-1:0] theta_max;
   logic [TW-1:0] heat;
   logic [TW-1:0] decayed;
   logic [TW:0] heat_sum;
   logic [TW+6:0] decayed_x100;
   logic above;
   logic ratio_ok;
   logic pick_now;
   logic expired;

   always_comb
   begin
      thr = (i_cfg.threshold_reference_select == ULT_REF_OBJECT)
         ? i_cfg.object_rated_unbalance_threshold : i_cfg.device_rated_unbalance_threshold;
      scale2 = i_cfg.object_scale * i_cfg.object_scale;
      scaled = i_seq.neg_mag2 * scale2;
      ref_mag2 = (i_cfg.threshold_reference_select == ULT_REF_OBJECT)
         ? scaled[MW+`ULT_Q16_SHIFT-1:`ULT_Q16_SHIFT] : i_seq.neg_mag2;
      thr2 = thr * thr;
      above = ref_mag2 > {8'h00, thr2};
      neg_pct = i_seq.neg_mag2 * `ULT_PCT_SQ;
      ratio2 = i_cfg.sequence_ratio_pickup_percent * i_cfg.sequence_ratio_pickup_percent;
      pos_pct = i_seq.pos_mag2 * ratio2;
      ratio_ok = !i_cfg.ratio_en || ({2'b00, neg_pct} > pos_pct);
      pick_now = i_cfg.enable && above && ratio_ok;
      // heat rate is excess over threshold squared
      theta_max = TW'(i_cfg.k_sec * TICKS_PER_S) << `ULT_Q16_SHIFT;
      heat = TW'(ref_mag2 - {8'h00, thr2});
      heat_sum = {1'b0, theta} + {1'b0, heat};
      decayed = theta - (theta >> i_cfg.cool_shift);
      decayed_x100 = decayed * `ULT_COLD_DIV;
      next_theta = theta;
      next_timer = timer;
      next_pickup = pickup;
      next_trip = trip;
      expired = 1'b0;
      if (i_clear)
      begin
         next_theta = '0;
         next_timer = '0;
         next_pickup = 1'b0;
         next_trip = 1'b0;
      end
      else if (i_tick)
      begin
         if (above)
         begin
            next_theta = heat_sum[TW] ? '1 : heat_sum[TW-1:0];
         end
         else
         begin
            next_theta = (decayed_x100 < {7'h00, theta_max}) ? '0 : decayed;
         end
         if (pick_now)
         begin
            next_timer = (timer == '1) ? timer : timer + 16'h0001;
         end
         else
         begin
            next_timer = '0;
         end
         if (i_cfg.curve == fixed_delay_curve)
         begin
            expired = next_timer >= i_cfg.delay_ticks;
         end
         else
         begin
            expired = next_theta > theta_max;
         end
         next_pickup = pick_now;
         next_trip = pick_now && expired;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         theta <= '0;
         timer <= '0;
         pickup <= 1'b0;
         trip <= 1'b0;
      end
      else
      begin
         theta <= next_theta;
         timer <= next_timer;
         pickup <= next_pickup;
         trip <= next_trip;
      end
   end

   assign o_pickup = pickup;
   assign o_trip = trip;

endmodule // ult_stage

// ===== verilog/ult_top.sv
`timescale 1ns/10ps
`include "ult_map.svh"


module ult_top
#(
   parameter int N_STAGES = 2,
   parameter int TICK_CYCLES = `ULT_TICK_PERIOD_NS / `ULT_CLK_PERIOD_NS
)
(
   input wire logic i_sys_clk,
   input wire logic i_arst_n,
   input wire logic i_sample_valid,
   input wire ult_pkg::ult_phases_t i_phases,
   input wire ult_pkg::ult_rot_t i_rotation,
   input wire logic i_clear_prot,
   input wire ult_pkg::ult_stage_cfg_t [N_STAGES-1:0] i_cfg,
   output logic o_sample_ready,
   output ult_pkg::ult_seq_t o_seq,
   output logic o_seq_valid,
   output logic o_tick,
   output logic [N_STAGES-1:0] o_pickup,
   output logic [N_STAGES-1:0] o_trip,
   output logic o_trip_any
);
   import ult_pkg::*;

   localparam int DW = $clog2(TICK_CYCLES + 1);
   localparam int unsigned TICKS_PER_S = `ULT_NS_PER_S / `ULT_TICK_PERIOD_NS;
   localparam int WW = `ULT_WIDE_W;
   localparam int SW = `ULT_SUM_W;

   ult_state_t state;
   ult_state_t next_state;
   ult_phases_t phases;
   ult_phases_t next_phases;
   ult_cplx_t a_l2;
   ult_cplx_t next_a_l2;
   ult_cplx_t a2_l2;
   ult_cplx_t next_a2_l2;
   ult_cplx_t a_l3;
   ult_cplx_t next_a_l3;
   ult_cplx_t a2_l3;
   ult_cplx_t next_a2_l3;
   ult_cplx_t pos_c;
   ult_cplx_t next_pos_c;
   ult_cplx_t neg_c;
   ult_cplx_t next_neg_c;
   ult_seq_t seq;
   ult_seq_t next_seq;
   logic seq_valid;
   logic next_seq_valid;
   logic [DW-1:0] div;
   logic [DW-1:0] next_div;
   logic tick;
   logic next_tick;
   logic trip_any;
   logic next_trip_any;
   logic [N_STAGES-1:0] stage_pickup;
   logic [N_STAGES-1:0] stage_trip;
   logic [`ULT_MAG_W-1:0] pos_mag;
   logic [`ULT_MAG_W-1:0] neg_mag;

   // Multiply by sqrt(3)/2; truncation bias is far below measurement noise
   function automatic logic signed [WW-1:0] mul_k(input logic signed [`ULT_CUR_W-1:0] x);
      logic signed [`ULT_CUR_W+16:0] p;
      p = x * `ULT_SQRT3_HALF;
      return WW'(p >>> `ULT_K_SHIFT);
   endfunction

   // Rotate by +120 degrees
   function automatic ult_cplx_t rot_a(input ult_phasor_t x);
      ult_cplx_t r;
      logic signed [WW-1:0] hr;
      logic signed [WW-1:0] hi;
      hr = WW'(x.re) >>> 1;
      hi = WW'(x.im) >>> 1;
      r.re = -hr - mul_k(x.im);
      r.im = mul_k(x.re) - hi;
      return r;
   endfunction

   // Rotate by +240 degrees
   function automatic ult_cplx_t rot_a2(input ult_phasor_t x);
      ult_cplx_t r;
      logic signed [WW-1:0] hr;
      logic signed [WW-1:0] hi;
      hr = WW'(x.re) >>> 1;
      hi = WW'(x.im) >>> 1;
      r.re = -hr + mul_k(x.im);
      r.im = -mul_k(x.re) - hi;
      return r;
   endfunction

   function automatic logic signed [WW-1:0] third(input logic signed [SW-1:0] s);
      logic signed [SW+16:0] p;
      p = s * `ULT_ONE_THIRD;
      return WW'(p >>> `ULT_THIRD_SHIFT);
   endfunction

   // Sum of three terms, scaled to one third
   function automatic ult_cplx_t seq_sum(input ult_phasor_t x, input ult_cplx_t y,
                                          input ult_cplx_t z);
      ult_cplx_t r;
      logic signed [SW-1:0] sr;
      logic signed [SW-1:0] si;
      sr = SW'(x.re) + SW'(y.re) + SW'(z.re);
      si = SW'(x.im) + SW'(y.im) + SW'(z.im);
      r.re = third(sr);
      r.im = third(si);
      return r;
   endfunction

   // Squared magnitude avoids a square root; thresholds are squared instead
   function automatic logic [`ULT_MAG_W-1:0] mag2(input ult_cplx_t c);
      logic signed [`ULT_MAG_W-1:0] sr;
      logic signed [`ULT_MAG_W-1:0] si;
      sr = c.re * c.re;
      si = c.im * c.im;
      return `ULT_MAG_W'(sr + si);
   endfunction

   // Evaluation tick divider
   always_comb
   begin
      next_tick = 1'b0;
      if (div == DW'(TICK_CYCLES - 1))
      begin
         next_div = '0;
         next_tick = 1'b1;
      end
      else
      begin
         next_div = div + DW'(1);
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         div <= '0;
         tick <= 1'b0;
      end
      else
      begin
         div <= next_div;
         tick <= next_tick;
      end
   end

   always_comb
   begin
      pos_mag = mag2(pos_c);
      neg_mag = mag2(neg_c);
   end

   // Sequence computation, one stage of arithmetic per state
   always_comb
   begin
      next_state = state;
      next_phases = phases;
      next_a_l2 = a_l2;
      next_a2_l2 = a2_l2;
      next_a_l3 = a_l3;
      next_a2_l3 = a2_l3;
      next_pos_c = pos_c;
      next_neg_c = neg_c;
      next_seq = seq;
      next_seq_valid = 1'b0;
      case (state)
         ULT_S_IDLE:
         begin
            if (i_sample_valid)
            begin
               next_phases = i_phases;
               next_state = ULT_S_ROTATE;
            end
         end
         ULT_S_ROTATE:
         begin
            next_a_l2 = rot_a(phases.l2);
            next_a2_l2 = rot_a2(phases.l2);
            next_a_l3 = rot_a(phases.l3);
            next_a2_l3 = rot_a2(phases.l3);
            next_state = ULT_S_SUM;
         end
         ULT_S_SUM:
         begin
            next_pos_c = seq_sum(phases.l1, a_l2, a2_l3);
            next_neg_c = seq_sum(phases.l1, a2_l2, a_l3);
            next_state = ULT_S_SQUARE;
         end
         ULT_S_SQUARE:
         begin
            if (i_rotation == ULT_ROT_ACB)
            begin
               next_seq.pos_mag2 = neg_mag;
               next_seq.neg_mag2 = pos_mag;
            end
            else
            begin
               next_seq.pos_mag2 = pos_mag;
               next_seq.neg_mag2 = neg_mag;
            end
            next_seq_valid = 1'b1;
            next_state = ULT_S_IDLE;
         end
         default:
         begin
            next_state = ULT_S_IDLE;
         end
      endcase
      if (i_clear_prot)
      begin
         next_state = ULT_S_IDLE;
         next_seq = '0;
         next_seq_valid = 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         state <= ULT_S_IDLE;
         phases <= '0;
         a_l2 <= '0;
         a2_l2 <= '0;
         a_l3 <= '0;
         a2_l3 <= '0;
         pos_c <= '0;
         neg_c <= '0;
         seq <= '0;
         seq_valid <= 1'b0;
      end
      else
      begin
         state <= next_state;
         phases <= next_phases;
         a_l2 <= next_a_l2;
         a2_l2 <= next_a2_l2;
         a_l3 <= next_a_l3;
         a2_l3 <= next_a2_l3;
         pos_c <= next_pos_c;
         neg_c <= next_neg_c;
         seq <= next_seq;
         seq_valid <= next_seq_valid;
      end
   end

   for (genvar g = 0; g < N_STAGES; g++)
   begin : g_stage
      ult_stage #(
         .TICKS_PER_S(TICKS_PER_S)
      ) u_stage (
         .i_sys_clk(i_sys_clk),
         .i_arst_n(i_arst_n),
         .i_tick(tick),
         .i_clear(i_clear_prot),
         .i_seq(seq),
         .i_cfg(i_cfg[g]),
         .o_pickup(stage_pickup[g]),
         .o_trip(stage_trip[g])
      );
   end

   // Summary trip lags the stage trips by one cycle
   always_comb
   begin
      next_trip_any = i_clear_prot ? 1'b0 : |stage_trip;
   end

   always_ff @(posedge i_sys_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         trip_any <= 1'b0;
      end
      else
      begin
         trip_any <= next_trip_any;
      end
   end

   // Samples offered while busy are ignored, not queued
   assign o_sample_ready = (state == ULT_S_IDLE);
   assign o_seq = seq;
   assign o_seq_valid = seq_valid;
   assign o_tick = tick;
   assign o_pickup = stage_pickup;
   assign o_trip = stage_trip;
   assign o_trip_any = trip_any;

endmodule // ult_top

// ===== tb/ult_properties.sv
`timescale 1ns/10ps

module ult_checks
#(
   parameter int N_STAGES = 2,
   parameter int TICK_CYCLES = 20
)
(
   input wire logic i_sys_clk,
   input wire logic i_arst_n,
   input wire logic i_sample_valid,
   input wire ult_pkg::ult_phases_t i_phases,
   input wire ult_pkg::ult_rot_t i_rotation,
   input wire logic i_clear_prot,
   input wire ult_pkg::ult_stage_cfg_t [N_STAGES-1:0] i_cfg,
   input wire logic o_sample_ready,
   input wire ult_pkg::ult_seq_t o_seq,
   input wire logic o_seq_valid,
   input wire logic o_tick,
   input wire logic [N_STAGES-1:0] o_pickup,
   input wire logic [N_STAGES-1:0] o_trip,
   input wire logic o_trip_any
);
   import ult_pkg::*;
   int gap;
   int next_gap;
   logic seen;
   logic next_seen;

   // First tick after reset has no prior tick to measure from
   always_comb
   begin
      next_gap = o_tick ? 0 : gap + 1;
      next_seen = seen | o_tick;
   end

   always_ff @(posedge i_sys_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         gap <= 0;
         seen <= 1'b0;
      end
      else
      begin
         gap <= next_gap;
         seen <= next_seen;
      end
   end

   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_arst_n);

   sequence take;
      i_sample_valid && o_sample_ready && !i_clear_prot;
   endsequence

   chk_seq_latency:
      assert property (take ##1 (!i_clear_prot)[*3] |-> ##1 o_seq_valid)
      else $error("sequence result late");
   chk_busy_window:
      assert property (take ##1 (!i_clear_prot)[*3] |-> ##1 o_sample_ready
         && !$past(o_sample_ready, 1) && !$past(o_sample_ready, 2) && !$past(o_sample_ready, 3))
      else $error("sample ready window wrong");
   chk_valid_pulse:
      assert property (o_seq_valid |=> !o_seq_valid)
      else $error("result pulse too long");
   chk_seq_hold:
      assert property ($changed(o_seq) |-> o_seq_valid || $past(i_clear_prot))
      else $error("sequence result changed alone");
   chk_tick_period:
      assert property (o_tick && seen |-> gap == TICK_CYCLES - 1)
      else $error("tick spacing wrong");
   chk_trip_pickup:
      assert property ((o_trip & ~o_pickup) == '0)
      else $error("trip without pickup");
   chk_trip_any:
      assert property (o_trip_any == (|$past(o_trip) && !$past(i_clear_prot)))
      else $error("combined trip wrong");
   chk_level_tick:
      assert property ($changed({o_pickup, o_trip}) |-> $past(o_tick) || $past(i_clear_prot))
      else $error("stage level moved off tick");
   chk_clear_all:
      assert property (i_clear_prot |=> o_pickup == '0 && o_trip == '0 && o_seq == '0 && !o_seq_valid)
      else $error("clear left state behind");

   cover property (take);
   cover property ($rose(o_trip[0]));
   cover property ($rose(o_trip_any));
   cover property (i_clear_prot && o_pickup != '0);
endmodule // ult_checks

bind ult_top ult_checks #(.N_STAGES(N_STAGES), .TICK_CYCLES(TICK_CYCLES)) chk_u
(
   .i_sys_clk(i_sys_clk),
   .i_arst_n(i_arst_n),
   .i_sample_valid(i_sample_valid),
   .i_phases(i_phases),
   .i_rotation(i_rotation),
   .i_clear_prot(i_clear_prot),
   .i_cfg(i_cfg),
   .o_sample_ready(o_sample_ready),
   .o_seq(o_seq),
   .o_seq_valid(o_seq_valid),
   .o_tick(o_tick),
   .o_pickup(o_pickup),
   .o_trip(o_trip),
   .o_trip_any(o_trip_any)
);

// ===== tb/ult_front.sv
`timescale 1ns/10ps

module ult_front
(
   input wire logic i_sys_clk,
   input wire logic i_ready,
   output logic o_valid,
   output ult_pkg::ult_phases_t o_phases
);
   import ult_pkg::*;

   initial
   begin
      o_valid = 1'b0;
      o_phases = '0;
   end

   // Offer one sample after gap cycles and hold it until the taking edge
   task automatic send(input ult_phases_t ph, input int gap);
      int waits;
      waits = 0;
      repeat (gap)
      begin
         @(posedge i_sys_clk);
         #1;
      end
      o_valid = 1'b1;
      o_phases = ph;
      while (i_ready !== 1'b1 && waits < 64)
      begin
         @(posedge i_sys_clk);
         #1;
         waits++;
      end
      @(posedge i_sys_clk);
      #1;
      o_valid = 1'b0;
      // Released lines must not keep looking like the last sample
      o_phases = ~ph;
   endtask
endmodule // ult_front

// ===== tb/test_unbalanced_load_trip_logic.sv
`timescale 1ns/10ps

module test_unbalanced_load_trip_logic;
   import ult_pkg::*;
   localparam int TC = 20;
   // One second of capability over 64 In^2 excess, in 1 ms ticks
   localparam int HEAT_TICKS = (1000 + 63) / 64;
   logic i_sys_clk;
   logic i_arst_n;
   logic sample_valid;
   ult_phases_t phases;
   ult_rot_t rot;
   logic clr;
   ult_stage_cfg_t [1:0] cfg;
   logic ready;
   ult_seq_t seq;
   logic seq_valid;
   logic tick;
   logic [1:0] pick;
   logic [1:0] trip;
   logic trip_any;
   int bad_count;
   int check_count;
   ult_phases_t bal;

   ult_top #(.N_STAGES(2), .TICK_CYCLES(TC)) dut_u
   (
      .i_sys_clk(i_sys_clk),
      .i_arst_n(i_arst_n),
      .i_sample_valid(sample_valid),
      .i_phases(phases),
      .i_rotation(rot),
      .i_clear_prot(clr),
      .i_cfg(cfg),
      .o_sample_ready(ready),
      .o_seq(seq),
      .o_seq_valid(seq_valid),
      .o_tick(tick),
      .o_pickup(pick),
      .o_trip(trip),
      .o_trip_any(trip_any)
   );

   ult_front front_u
   (
      .i_sys_clk(i_sys_clk),
      .i_ready(ready),
      .o_valid(sample_valid),
      .o_phases(phases)
   );

   always #2.5 i_sys_clk = ~i_sys_clk;

   task close_out;
      if (bad_count == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task check_bits(input logic [1:0] got, input logic [1:0] exp, input string what);
      check_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: %s got %b want %b", $time, what, got, exp);
      end
   endtask

   // Truncation in rotation and division leaves a small error
   task check_mag(input logic [39:0] got, input logic [39:0] exp, input string what);
      check_count++;
      if (^got === 1'bx || got < exp - (exp >> 5) || got > exp + (exp >> 5) + 40'h0400)
      begin
         bad_count++;
         $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   function automatic ult_phases_t ph1(input logic [15:0] amp);
      ph1 = '0;
      ph1.l1.re = amp;
   endfunction

   function automatic ult_stage_cfg_t mk(input logic en, input logic objr, input logic heat,
      input logic [7:0] pct, input logic [15:0] thr, input logic [15:0] dly);
      mk = '0;
      mk.enable = en;
      mk.threshold_reference_select = objr ? ULT_REF_OBJECT : ULT_REF_DEVICE;
      mk.curve = heat ? heat_based_curve : fixed_delay_curve;
      mk.ratio_en = (pct != 8'h00);
      mk.sequence_ratio_pickup_percent = pct;
      mk.device_rated_unbalance_threshold = thr;
      mk.object_rated_unbalance_threshold = thr;
      mk.object_scale = 16'h0200;
      mk.delay_ticks = dly;
      mk.k_sec = 16'h0001;
      mk.cool_shift = 5'h0A;
   endfunction

   task tick_wait(input int n);
      int k;
      repeat (n)
      begin
         k = 0;
         do
         begin
            @(posedge i_sys_clk);
            #1;
            k++;
         end while (tick !== 1'b1 && k < 2 * TC);
         @(posedge i_sys_clk);
         #1;
      end
   endtask

   // Sample lands right after a tick, well before the next one
   task apply(input ult_phases_t ph, input int gap);
      tick_wait(1);
      front_u.send(ph, gap);
      repeat (3) @(posedge i_sys_clk);
      #1;
      check_bits({1'b0, seq_valid}, 2'b01, "result pulse");
   endtask

   task clear_fn;
      clr = 1'b1;
      @(posedge i_sys_clk);
      #1;
      clr = 1'b0;
      @(posedge i_sys_clk);
      #1;
   endtask

   task t_sequence;
      apply(bal, 5);
      check_mag(seq.pos_mag2, 40'h00_0001_0000, "pos abc");
      check_mag(seq.neg_mag2, 40'h00_0000_0000, "neg abc");
      rot = ULT_ROT_ACB;
      apply(bal, 0);
      check_mag(seq.pos_mag2, 40'h00_0000_0000, "pos acb");
      check_mag(seq.neg_mag2, 40'h00_0001_0000, "neg acb");
      rot = ULT_ROT_ABC;
      apply(ph1(16'h0300), 0);
      check_mag(seq.pos_mag2, 40'h00_0001_0000, "pos one phase");
      check_mag(seq.neg_mag2, 40'h00_0001_0000, "neg one phase");
   endtask

   task t_threshold;
      cfg[0] = mk(1'b1, 1'b0, 1'b0, 8'h00, 16'h0180, 16'h0001);
      cfg[1] = mk(1'b1, 1'b1, 1'b0, 8'h00, 16'h0180, 16'h0001);
      tick_wait(1);
      check_bits(pick, 2'b10, "pickup by reference");
      check_bits(trip, 2'b10, "trip by reference");
      cfg[0] = mk(1'b1, 1'b0, 1'b0, 8'h00, 16'h0080, 16'h0001);
      cfg[1] = mk(1'b1, 1'b1, 1'b0, 8'h00, 16'h0280, 16'h0001);
      tick_wait(1);
      check_bits(pick, 2'b01, "pickup swapped reference");
      cfg[0] = mk(1'b1, 1'b0, 1'b0, 8'h32, 16'h0080, 16'h0001);
      cfg[1] = mk(1'b1, 1'b0, 1'b0, 8'h96, 16'h0080, 16'h0001);
      tick_wait(1);
      check_bits(pick, 2'b01, "ratio pickup");
      cfg[1] = mk(1'b1, 1'b0, 1'b0, 8'h32, 16'h0180, 16'h0001);
      tick_wait(1);
      check_bits(pick, 2'b01, "threshold over ratio");
   endtask

   task t_fixed;
      cfg[0] = mk(1'b1, 1'b0, 1'b0, 8'h00, 16'h0080, 16'h0003);
      cfg[1] = mk(1'b0, 1'b0, 1'b0, 8'h00, 16'h0080, 16'h0003);
      clear_fn;
      apply(ph1(16'h0300), 0);
      tick_wait(2);
      check_bits(pick, 2'b01, "fixed pickup");
      check_bits(trip, 2'b00, "fixed early");
      tick_wait(1);
      check_bits(trip, 2'b01, "fixed on time");
      @(posedge i_sys_clk);
      #1;
      check_bits({1'b0, trip_any}, 2'b01, "combined trip");
      apply(ph1(16'h0000), 0);
      tick_wait(1);
      check_bits({pick[0], trip[0]}, 2'b00, "dropout");
      apply(ph1(16'h0300), 0);
      tick_wait(2);
      check_bits(trip, 2'b00, "restart early");
      tick_wait(1);
      check_bits(trip, 2'b01, "restart on time");
      clear_fn;
      check_bits({pick[0], trip[0]}, 2'b00, "clear stage");
      check_mag(seq.neg_mag2, 40'h00_0000_0000, "clear result");
      // Refill before the next tick so only a cleared timer keeps trip low
      front_u.send(ph1(16'h0300), 0);
      repeat (3) @(posedge i_sys_clk);
      #1;
      check_bits({1'b0, seq_valid}, 2'b01, "result pulse");
      tick_wait(2);
      check_bits(trip, 2'b00, "timer cleared");
   endtask

   task t_heat;
      clear_fn;
      cfg[0] = mk(1'b1, 1'b0, 1'b1, 8'h00, 16'h0000, 16'h0001);
      cfg[1] = mk(1'b1, 1'b0, 1'b0, 8'h00, 16'h0000, 16'h0001);
      apply(ph1(16'h1800), 0);
      for (int k = 1; k <= HEAT_TICKS + 1; k++)
      begin
         tick_wait(1);
         if (k <= HEAT_TICKS - 2)
            check_bits(trip, 2'b10, "heat early");
         if (k == HEAT_TICKS + 1)
            check_bits(trip, 2'b11, "heat trip");
      end
      clear_fn;
      cfg[0].enable = 1'b0;
      apply(ph1(16'h1800), 0);
      tick_wait(HEAT_TICKS + 1);
      check_bits(pick, 2'b10, "disabled stage");
      cfg[0].enable = 1'b1;
      tick_wait(1);
      check_bits(trip, 2'b11, "stored heat");
      clear_fn;
      apply(ph1(16'h1800), 0);
      tick_wait(1);
      check_bits(trip, 2'b10, "heat cleared");
   endtask

   initial
   begin
      #100000;
      bad_count++;
      close_out;
   end

   initial
   begin
      i_sys_clk = 1'b0;
      i_arst_n = 1'b0;
      rot = ULT_ROT_ABC;
      clr = 1'b0;
      cfg = '0;
      bad_count = 0;
      check_count = 0;
      bal = ph1(16'h0100);
      bal.l2.re = 16'hFF80;
      bal.l2.im = 16'hFF22;
      bal.l3.re = 16'hFF80;
      bal.l3.im = 16'h00DE;
      repeat (8) @(posedge i_sys_clk);
      #1;
      i_arst_n = 1'b1;
      t_sequence;
      t_threshold;
      t_fixed;
      t_heat;
      close_out;
   end
endmodule // test_unbalanced_load_trip_logic
